// *** rfhx_pkg.sv ***
// Purpose: Shared types and constants of the exclusive-control arbiter
// Assumes: Core clock 100 MHz; link side on its own clock
// Notes: Opcodes come pre-decoded from the serial framing logic
package rfhx_pkg;
   // Host opcodes as decoded upstream
   localparam logic [3:0] OP_READ = 4'h1;
   localparam logic [3:0] OP_WRITE = 4'h2;
   localparam logic [3:0] OP_STATUS = 4'h3;
   localparam logic [3:0] OP_REG_WRITE = 4'h4;
   localparam logic [3:0] OP_REG_READ = 4'h5;
   localparam logic [3:0] OP_TUN_POLL = 4'h6;
   localparam logic [3:0] OP_TUN_REPLY = 4'h7;
   // Answer wait time and its cycle count
   localparam int CORE_CLK_MHZ = 100;
   localparam int AWT_US = 10;
   localparam int AWT_CYC = AWT_US * CORE_CLK_MHZ;
   // Toggle event and level bit indices
   localparam int EV_START = 0;
   localparam int EV_START_TUN = 1;
   localparam int EV_DONE = 2;
   localparam int LV_EXCL = 0;
   localparam int LV_SER = 1;
   localparam int LV_STOP = 2;
   localparam int LV_WES = 3;
   localparam int LV_FINAL = 4;
   // Exclusive-control state
   typedef enum logic [2:0] {ST_IDLE, ST_RF, ST_SER, ST_WQ, ST_WA} rfhx_state_e;
   // Answer given to a host command
   typedef enum logic [3:0] {RP_NONE, RP_EXEC, RP_NORMAL, RP_BUSY, RP_HOST_BUSY,
      RP_TUN_ERR, RP_UNIMPL, RP_TUN_DET, RP_TUN_DET_OK, RP_ADVANCE} rfhx_reply_e;
   // Action toward the reader/writer
   typedef enum logic [1:0] {RA_SILENT, RA_NORMAL, RA_WTX} rfhx_rf_act_e;
   typedef struct packed {
      logic valid;
      logic addr_match;
      logic [3:0] op;
      logic rf_stop;
   } rfhx_host_cmd_s;
   typedef struct packed {
      logic valid;
      rfhx_reply_e code;
   } rfhx_host_rsp_s;
   typedef struct packed {
      logic valid;
      logic iso;
      logic wtx_kind;
      logic tunnel;
   } rfhx_rf_cmd_s;
   typedef struct packed {
      logic valid;
      rfhx_rf_act_e act;
   } rfhx_rf_rsp_s;
endpackage : rfhx_pkg

// *** rfhx_arbiter.sv ***
// Purpose: Decide the answer to host and RF commands during exclusivity
// Assumes: Framing, memory and RF analog logic sit outside this block
// Notes: Core state lives on core_clk_in; RF decisions on rf_clk_in
// Functional notes
// R1: One command at a time until response sent
// R2: Tunnel exclusivity lasts until final RF response
// R3: Answer only matching address; unknown opcode errors
// R4: RF busy: busy, normal, or tunnel error
// R5: Serial busy: every host command gets host-busy; unknown opcodes get unimplemented instead
// R6: Early slave read request gets host-busy
// R7: Poll wait: unimplemented, detect, poll advances
// R8: Poll wait: register commands detect or normal
// R9: Reply wait: unimplemented, detect, reply completes
// R10: Busied host command raises no interrupt
// R11: JIS commands silent during any exclusivity
// R12: ISO silent when wait extension off
// R13: Serial busy with extension: WTX or answer
// R14: RF stop setting silences ISO during serial
// R15: Host reply first, then tunnel interrupt
// R16: Serial data not guaranteed on RF collision
// R17: Host stops RF around serial access
// R18: Host waits after self reset
// R19: Register write bit3 stops, bit0 resets; only the RF stop bit (rf_stop) is decoded here, no reset is done
// R20: Carrier loss in tunnel returns idle; in the final RF phase the state stays ST_RF
// R21: Reply wait timer restarts on other commands
// R22: Encoded state selects every decision
// R23: Refused commands leave no side effect
`timescale 1ns/1ps
module rfhx_arbiter #(
   parameter int unsigned AWT_CYCLES = rfhx_pkg::AWT_CYC
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire rfhx_pkg::rfhx_host_cmd_s host_cmd_in,
   input wire logic host_rdreq_in,
   input wire logic host_proc_done_in,
   input wire logic host_resp_sent_in,
   input wire logic wait_extension_select_in,
   output rfhx_pkg::rfhx_host_rsp_s host_rsp_out,
   output logic irq_out,
   output rfhx_pkg::rfhx_state_e state_out,
   output logic rf_stopped_out,
   input wire logic rf_clk_in,
   input wire rfhx_pkg::rfhx_rf_cmd_s rf_cmd_in,
   input wire logic rf_resp_done_in,
   input wire logic carrier_in,
   output rfhx_pkg::rfhx_rf_rsp_s rf_rsp_out,
   output logic rf_final_req_out
);
   import rfhx_pkg::*;
   localparam int AW = $clog2(AWT_CYCLES + 1);

   // Core-side state
   rfhx_state_e state_q, state_d, view;
   logic tun_q, tun_d;          // RF phase belongs to a tunnel command
   logic fin_q, fin_d;          // Final tunnel response to reader pending
   logic irq_pend_q, irq_pend_d;
   logic irq_q;
   logic irq_done_q;            // Serial command interrupt already raised
   logic hrsp_open_q;           // Immediate reply still being shifted out
   logic rf_stop_q;
   logic [AW-1:0] awt_q;
   rfhx_host_rsp_s hrsp_q;
   rfhx_reply_e code;

   // Toggle events from the RF domain, three stages each
   logic [2:0] ev_tgl_q;        // Toggled on the RF clock, one bit per event
   logic [2:0] ev_s1, ev_s2, ev_s3;
   logic [1:0] car_s;
   wire [2:0] ev_p = ev_s2 ^ ev_s3;
   wire car_lost = !car_s[1];

   // Capture RF events; stage one feeds only stage two
   always_ff @(posedge core_clk_in)
   begin
      ev_s1 <= ev_tgl_q;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      car_s <= {car_s[0], carrier_in};
   end

   // Host command decode
   wire cmd_ok = host_cmd_in.valid && host_cmd_in.addr_match; // R3
   wire [3:0] op = host_cmd_in.op;
   wire op_impl = (op >= OP_READ) && (op <= OP_TUN_REPLY); // R3
   wire is_rw = (op == OP_READ) || (op == OP_WRITE);
   wire is_reg = (op == OP_REG_WRITE) || (op == OP_REG_READ);
   wire stop_req = (op == OP_REG_WRITE) && host_cmd_in.rf_stop;
   wire rf_start = (ev_p[EV_START] || ev_p[EV_START_TUN]);
   // An RF start seen in idle outranks a host command in the same cycle
   assign view = (state_q == ST_IDLE && rf_start) ? ST_RF : state_q; // R22

   // Reply table, selected from the state
   always_comb
   begin
      code = RP_UNIMPL;
      if (!op_impl)
         code = RP_UNIMPL; // R3
      else
      begin
         unique case (view)
            ST_IDLE: code = RP_EXEC;
            ST_RF:
               if (is_reg)
                  code = RP_NORMAL; // R4
               else if (op == OP_TUN_POLL || op == OP_TUN_REPLY)
                  code = RP_TUN_ERR; // R4
               else
                  code = RP_BUSY; // R4 R16
            ST_SER: code = RP_HOST_BUSY; // R5
            ST_WQ:
               if (op == OP_TUN_POLL)
                  code = RP_ADVANCE; // R7
               else if (op == OP_STATUS)
                  code = RP_TUN_DET; // R7
               else if (stop_req)
                  code = RP_NORMAL; // R8
               else if (is_reg)
                  code = RP_TUN_DET_OK; // R8
               else
                  code = RP_UNIMPL; // R7
            ST_WA:
               if (op == OP_TUN_REPLY)
                  code = RP_ADVANCE; // R9
               else if (op == OP_STATUS)
                  code = RP_TUN_DET; // R9
               else if (is_reg)
                  code = RP_NORMAL; // R9
               else
                  code = RP_UNIMPL; // R9
         endcase
      end
   end

   // Register writes only take effect when actually executed
   wire reg_wr_acc = cmd_ok && (op == OP_REG_WRITE) &&
      (code == RP_EXEC || code == RP_NORMAL || code == RP_TUN_DET_OK); // R23
   wire early_rd = host_rdreq_in && (state_q == ST_SER) && !irq_done_q; // R6
   wire awt_out = (awt_q == AW'(AWT_CYCLES - 1));
   wire awt_clr = cmd_ok && (op != OP_TUN_REPLY); // R21
   wire irq_fire = irq_pend_q && !hrsp_open_q && !irq_q; // R15

   // Next state of the exclusive control
   always_comb
   begin
      state_d = state_q;
      tun_d = tun_q;
      fin_d = fin_q;
      irq_pend_d = irq_pend_q && !irq_fire;
      unique case (view)
         ST_IDLE:
            if (cmd_ok && code == RP_EXEC)
               state_d = ST_SER; // R1
         ST_RF:
         begin
            // Reader start seen in idle: enter the RF phase now
            if (state_q == ST_IDLE)
            begin
               state_d = ST_RF; // R1
               tun_d = ev_p[EV_START_TUN]; // R2
            end
            if (ev_p[EV_DONE])
            begin
               state_d = tun_q ? ST_WQ : ST_IDLE; // R2
               irq_pend_d = tun_q;
               fin_d = 1'b0;
               tun_d = 1'b0;
            end
            else if (tun_q && car_lost)
            begin
               state_d = ST_IDLE; // R20
               tun_d = 1'b0;
            end
         end
         ST_SER:
         begin
            if (host_proc_done_in && !irq_done_q)
               irq_pend_d = 1'b1; // R10
            if (host_resp_sent_in && irq_done_q)
               state_d = ST_IDLE; // R1
         end
         ST_WQ:
            if (car_lost)
               state_d = ST_IDLE; // R20
            else if (cmd_ok && code == RP_ADVANCE)
               state_d = ST_WA; // R7
         ST_WA:
            if (car_lost || (awt_out && !awt_clr))
               state_d = ST_IDLE; // R20
            else if (cmd_ok && code == RP_ADVANCE)
            begin
               state_d = ST_RF; // R9
               fin_d = 1'b1; // R2
            end
      endcase
   end

   // State, flags and interrupt
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         state_q <= ST_IDLE;
         tun_q <= 1'b0;
         fin_q <= 1'b0;
         irq_pend_q <= 1'b0;
         irq_q <= 1'b0;
         irq_done_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         tun_q <= tun_d;
         fin_q <= fin_d;
         irq_pend_q <= irq_pend_d;
         irq_q <= irq_fire; // R15
         // Cleared on leaving the serial phase
         irq_done_q <= (state_d == ST_SER) && (irq_done_q || irq_fire);
      end
   end

   // Host reply, reply-open flag and RF stop setting
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         hrsp_q <= '0;
         hrsp_open_q <= 1'b0;
         rf_stop_q <= 1'b0;
      end
      else
      begin
         hrsp_q.valid <= cmd_ok || early_rd;
         hrsp_q.code <= early_rd ? RP_HOST_BUSY : (cmd_ok ? code : RP_NONE); // R6
         // Set wins over the clear of a finished reply
         if ((cmd_ok && code != RP_EXEC) || early_rd)
            hrsp_open_q <= 1'b1;
         else if (host_resp_sent_in)
            hrsp_open_q <= 1'b0;
         if (reg_wr_acc)
            rf_stop_q <= host_cmd_in.rf_stop; // R19
      end
   end

   // Answer-wait timer of the reply wait
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in || state_q != ST_WA || awt_clr)
         awt_q <= '0; // R21
      else if (!awt_out)
         awt_q <= awt_q + AW'(1);
   end

   assign host_rsp_out = hrsp_q;
   assign irq_out = irq_q;
   assign state_out = state_q;
   assign rf_stopped_out = rf_stop_q;

   // Levels handed to the RF domain, registered before crossing
   logic [4:0] lv_q;
   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
         lv_q <= '0;
      else
      begin
         lv_q[LV_EXCL] <= (state_q != ST_IDLE); // R11
         lv_q[LV_SER] <= (state_q == ST_SER);
         lv_q[LV_STOP] <= rf_stop_q;
         lv_q[LV_WES] <= wait_extension_select_in;
         lv_q[LV_FINAL] <= fin_q;
      end
   end

   // RF domain: reset and level synchronisers
   logic [1:0] rrst_s;
   logic [4:0] lv_s1, lv_s2;
   wire rrst = rrst_s[1];
   always_ff @(posedge rf_clk_in)
   begin
      rrst_s <= {rrst_s[0], reset_in};
      lv_s1 <= lv_q;
      lv_s2 <= lv_s1;
   end

   // RF-side decision
   logic rf_busy_q;
   rfhx_rf_rsp_s rrsp_q;
   rfhx_rf_act_e act;
   wire blocked = rf_busy_q || lv_s2[LV_EXCL]; // R1
   wire accept = rf_cmd_in.valid && !blocked;
   // Extension only while serial runs, RF not stopped
   wire wtx_ok = rf_cmd_in.iso && lv_s2[LV_WES] && lv_s2[LV_SER] &&
      !lv_s2[LV_STOP] && !rf_busy_q; // R13 R14
   always_comb
   begin
      act = RA_SILENT; // R11 R12
      if (accept)
         act = RA_NORMAL;
      else if (wtx_ok)
         act = rf_cmd_in.wtx_kind ? RA_WTX : RA_NORMAL; // R13
   end

   // RF busy flag, event toggles and reader response
   always_ff @(posedge rf_clk_in)
   begin
      if (rrst)
      begin
         rf_busy_q <= 1'b0;
         ev_tgl_q <= '0;
         rrsp_q <= '0;
      end
      else
      begin
         if (accept)
            rf_busy_q <= 1'b1; // R1
         else if (rf_resp_done_in)
            rf_busy_q <= 1'b0;
         if (accept && !rf_cmd_in.tunnel)
            ev_tgl_q[EV_START] <= !ev_tgl_q[EV_START];
         if (accept && rf_cmd_in.tunnel)
            ev_tgl_q[EV_START_TUN] <= !ev_tgl_q[EV_START_TUN]; // R2
         // Any sent response, including the final tunnel one, ends RF phase
         if (rf_resp_done_in)
            ev_tgl_q[EV_DONE] <= !ev_tgl_q[EV_DONE];
         rrsp_q.valid <= rf_cmd_in.valid;
         rrsp_q.act <= act;
      end
   end

   assign rf_rsp_out = rrsp_q;
   assign rf_final_req_out = lv_s2[LV_FINAL];

   // Checks on the core clock
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   sequence s_poll;
      state_q == ST_WQ && !car_lost && cmd_ok && op == OP_TUN_POLL;
   endsequence
   sequence s_reply;
      state_q == ST_WA && !car_lost && cmd_ok && op == OP_TUN_REPLY;
   endsequence
   property p_r3;
      host_cmd_in.valid && !host_cmd_in.addr_match && !early_rd |=> !hrsp_q.valid;
   endproperty
   a_r3: assert property (p_r3) else $error("unmatched address answered"); // R3
   property p_r4;
      state_q == ST_RF && cmd_ok && op == OP_READ |=> hrsp_q.code == RP_BUSY;
   endproperty
   a_r4: assert property (p_r4) else $error("read not busied during RF"); // R4
   property p_r5;
      state_q == ST_SER && cmd_ok && op_impl |=> hrsp_q.code == RP_HOST_BUSY;
   endproperty
   a_r5: assert property (p_r5) else $error("serial busy not reported"); // R5
   property p_r7;
      s_poll |=> state_q == ST_WA && hrsp_q.code == RP_ADVANCE;
   endproperty
   a_r7: assert property (p_r7) else $error("poll did not advance"); // R7
   property p_r9;
      s_reply ##1 (state_q == ST_RF) |-> fin_q ##[1:4] lv_q[LV_FINAL];
   endproperty
   a_r9: assert property (p_r9) else $error("reply did not start final"); // R9
   property p_r15;
      irq_out |-> !$past(hrsp_open_q);
   endproperty
   a_r15: assert property (p_r15) else $error("irq raised over open reply"); // R15
   property p_r20;
      state_q == ST_WQ && car_lost |=> state_q == ST_IDLE;
   endproperty
   a_r20: assert property (p_r20) else $error("carrier loss ignored"); // R20
   property p_r21;
      state_q == ST_WA && awt_clr |=> awt_q == '0;
   endproperty
   a_r21: assert property (p_r21) else $error("wait timer not restarted"); // R21
   property p_r23;
      state_q == ST_SER && cmd_ok |=> rf_stop_q == $past(rf_stop_q) && state_q != ST_WA;
   endproperty
   a_r23: assert property (p_r23) else $error("busied command had effect"); // R23
   property p_r10;
      state_q == ST_SER && irq_done_q && cmd_ok |=> !irq_pend_q [*2];
   endproperty
   a_r10: assert property (p_r10) else $error("busied command raised irq"); // R10

   // Checks on the RF clock
   property p_r11;
      @(posedge rf_clk_in) disable iff (rrst)
      rf_cmd_in.valid && !rf_cmd_in.iso && blocked |=> rrsp_q.act == RA_SILENT;
   endproperty
   a_r11: assert property (p_r11) else $error("JIS answered while exclusive"); // R11
   property p_r14;
      @(posedge rf_clk_in) disable iff (rrst)
      rf_cmd_in.valid && blocked && lv_s2[LV_STOP] |=> rrsp_q.act == RA_SILENT;
   endproperty
   a_r14: assert property (p_r14) else $error("ISO answered with RF stopped"); // R14
endmodule : rfhx_arbiter

// *** rfhx_reader_model.sv ***
// Purpose: Reader/writer model driving the link side of the arbiter
// Assumes: Carrier clock runs free while the field is on
// Notes: Lines show the inverse of the last frame outside frames
`timescale 1ns/1ps
module rfhx_reader_model (
   input wire logic rf_clk_in,
   input wire rfhx_pkg::rfhx_rf_rsp_s rf_rsp_in,
   output rfhx_pkg::rfhx_rf_cmd_s rf_cmd_out,
   output logic rf_resp_done_out,
   output logic carrier_out
);
   import rfhx_pkg::*;
   // Quiet field with carrier present
   initial
   begin
      rf_cmd_out = '0;
      rf_resp_done_out = 1'b0;
      carrier_out = 1'b1;
   end
   // One frame held over one taking edge; answer read while it stands
   task automatic send(input logic iso, input logic wtx, input logic tun,
      output rfhx_rf_rsp_s rsp);
      @(negedge rf_clk_in);
      rf_cmd_out = '{valid: 1'b1, iso: iso, wtx_kind: wtx, tunnel: tun};
      @(negedge rf_clk_in);
      // Answer lasts one link cycle after the taking edge
      rsp = rf_rsp_in;
      rf_cmd_out = '{valid: 1'b0, iso: ~iso, wtx_kind: ~wtx, tunnel: ~tun};
   endtask : send
   // End of the device's answer to the reader
   task automatic done();
      @(negedge rf_clk_in);
      rf_resp_done_out = 1'b1;
      @(negedge rf_clk_in);
      rf_resp_done_out = 1'b0;
   endtask : done
   // Field on or off
   task automatic carrier(input logic on);
      @(negedge rf_clk_in);
      carrier_out = on;
   endtask : carrier
endmodule : rfhx_reader_model

// *** rfhx_arbiter_test.sv ***
// Purpose: Self-checking bench of the exclusive-control arbiter
// Assumes: Host side driven on falling core edges
// Notes: Answer wait shortened to 20 cycles
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin failures++; \
   $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module rfhx_arbiter_test;
   import rfhx_pkg::*;
   localparam int ANSWER_WAIT_TIME = 20; // Short answer wait
   logic core_clk_in = 1'b0;
   logic rf_clk_in = 1'b0;
   logic reset_in = 1'b1;
   rfhx_host_cmd_s host_cmd_in = '0;
   logic host_rdreq_in = 1'b0;
   logic host_proc_done_in = 1'b0;
   logic host_resp_sent_in = 1'b0;
   logic wait_extension_select_in = 1'b0;
   rfhx_host_rsp_s host_rsp_out;
   logic irq_out;
   rfhx_state_e state_out;
   logic rf_stopped_out;
   rfhx_rf_cmd_s rf_cmd_in;
   logic rf_resp_done_in;
   logic carrier_in;
   rfhx_rf_rsp_s rf_rsp_out;
   logic rf_final_req_out;
   int failures = 0;
   int samples_checked = 0;
   int irq_n = 0; // Interrupt pulses seen
   int n0;
   // Expected host answers by opcode in the RF, poll-wait and reply-wait states
   rfhx_reply_e e_rf[1:7] = '{RP_BUSY, RP_BUSY, RP_BUSY, RP_NORMAL, RP_NORMAL,
      RP_TUN_ERR, RP_TUN_ERR};
   rfhx_reply_e e_wq[1:5] = '{RP_UNIMPL, RP_UNIMPL, RP_TUN_DET, RP_TUN_DET_OK, RP_TUN_DET_OK};
   rfhx_reply_e e_wa[1:6] = '{RP_UNIMPL, RP_UNIMPL, RP_TUN_DET, RP_NORMAL, RP_NORMAL,
      RP_UNIMPL};
   rfhx_arbiter #(.AWT_CYCLES(ANSWER_WAIT_TIME)) dut (.core_clk_in, .reset_in, .host_cmd_in,
      .host_rdreq_in, .host_proc_done_in, .host_resp_sent_in, .wait_extension_select_in,
      .host_rsp_out, .irq_out, .state_out, .rf_stopped_out, .rf_clk_in, .rf_cmd_in,
      .rf_resp_done_in, .carrier_in, .rf_rsp_out, .rf_final_req_out);
   rfhx_reader_model rdr (.rf_clk_in, .rf_rsp_in(rf_rsp_out), .rf_cmd_out(rf_cmd_in),
      .rf_resp_done_out(rf_resp_done_in), .carrier_out(carrier_in));
   // Core clock, then an unrelated link clock
   initial
   begin
      forever #5 core_clk_in = ~core_clk_in;
   end
   initial
   begin
      #3;
      forever #62.5 rf_clk_in = ~rf_clk_in;
   end
   // Count interrupt pulses
   always @(posedge core_clk_in)
      if (irq_out === 1'b1) irq_n++;
   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   // One host command or early read request; RP_NONE means no answer
   task automatic hc(input logic [3:0] op, input logic stp, input logic am,
      input logic rq, input rfhx_reply_e ex);
      @(negedge core_clk_in);
      host_cmd_in = '{valid: ~rq, addr_match: am, op: op, rf_stop: stp};
      host_rdreq_in = rq;
      @(negedge core_clk_in);
      // Reply stands only in the cycle after the taking edge
      `CHK("rsp_valid", (ex != RP_NONE), host_rsp_out.valid)
      if (ex != RP_NONE) `CHK("rsp_code", ex, host_rsp_out.code)
      host_cmd_in = '0;
      host_rdreq_in = 1'b0;
      @(negedge core_clk_in);
   endtask : hc
   // Processing finished or reply sent
   task automatic pulse(input logic sent);
      @(negedge core_clk_in);
      host_resp_sent_in = sent;
      host_proc_done_in = ~sent;
      @(negedge core_clk_in);
      host_resp_sent_in = 1'b0;
      host_proc_done_in = 1'b0;
   endtask : pulse
   // Bounded wait for a state; a miss ends the run
   task automatic wait_st(input rfhx_state_e ex);
      for (int k = 0; k < 60 && state_out !== ex; k++) @(negedge core_clk_in);
      `CHK("state", ex, state_out)
      if (state_out !== ex) stop_test();
   endtask : wait_st
   // Reader command and its expected action
   task automatic rfc(input logic iso, input logic wtx, input logic tun, input rfhx_rf_act_e ex);
      rfhx_rf_rsp_s r;
      rdr.send(iso, wtx, tun, r);
      `CHK("rf_valid", 1'b1, r.valid)
      `CHK("rf_act", ex, r.act)
   endtask : rfc
   // Full serial command completion: close open replies, interrupt, final reply
   task automatic ser_end();
      pulse(1'b1);
      pulse(1'b0);
      pulse(1'b1);
      wait_st(ST_IDLE);
   endtask : ser_end
   initial
   begin
      // Long enough for the link domain's reset copy too
      repeat (40) @(negedge core_clk_in);
      reset_in = 1'b0;
      repeat (8) @(negedge core_clk_in);
      `CHK("state", ST_IDLE, state_out)
      hc(4'h1, 1'b0, 1'b0, 1'b0, RP_NONE);
      hc(4'hF, 1'b0, 1'b1, 1'b0, RP_UNIMPL);
      hc(4'h5, 1'b0, 1'b1, 1'b0, RP_EXEC);
      `CHK("state", ST_SER, state_out)
      n0 = irq_n;
      for (int i = 1; i < 8; i++) hc(4'(i), 1'b0, 1'b1, 1'b0, RP_HOST_BUSY);
      hc(4'h3, 1'b0, 1'b1, 1'b1, RP_HOST_BUSY);
      rfc(1'b0, 1'b1, 1'b0, RA_SILENT);
      rfc(1'b1, 1'b1, 1'b0, RA_SILENT);
      wait_extension_select_in = 1'b1;
      repeat (4) @(negedge rf_clk_in);
      rfc(1'b1, 1'b1, 1'b0, RA_WTX);
      rdr.done();
      rfc(1'b1, 1'b0, 1'b0, RA_NORMAL);
      rdr.done();
      `CHK("irq_cnt", 0, irq_n - n0)
      pulse(1'b1);
      pulse(1'b0);
      // Busied command after the interrupt must not raise another
      hc(4'h3, 1'b0, 1'b1, 1'b0, RP_HOST_BUSY);
      pulse(1'b1);
      wait_st(ST_IDLE);
      repeat (6) @(negedge core_clk_in);
      `CHK("irq_cnt", 1, irq_n - n0)
      // Stop setting silences extension answers
      hc(4'h4, 1'b1, 1'b1, 1'b0, RP_EXEC);
      ser_end();
      `CHK("rf_stop", 1'b1, rf_stopped_out)
      hc(4'h5, 1'b0, 1'b1, 1'b0, RP_EXEC);
      // Let the serial phase cross into the link domain first
      repeat (4) @(negedge rf_clk_in);
      rfc(1'b1, 1'b1, 1'b0, RA_SILENT);
      ser_end();
      hc(4'h4, 1'b0, 1'b1, 1'b0, RP_EXEC);
      ser_end();
      `CHK("rf_stop", 1'b0, rf_stopped_out)
      // Settling pause after restart, scaled down for the run length
      repeat (30) @(negedge core_clk_in);
      // Tunnel sequence
      pulse(1'b1);
      // Idle must reach the link domain before a reader frame is taken
      repeat (4) @(negedge rf_clk_in);
      n0 = irq_n;
      rfc(1'b0, 1'b0, 1'b1, RA_NORMAL);
      wait_st(ST_RF);
      for (int i = 1; i < 8; i++) hc(4'(i), 1'b0, 1'b1, 1'b0, e_rf[i]);
      rfc(1'b0, 1'b0, 1'b0, RA_SILENT);
      `CHK("state", ST_RF, state_out)
      rdr.done();
      wait_st(ST_WQ);
      repeat (4) @(negedge core_clk_in);
      `CHK("irq_cnt", 0, irq_n - n0)
      pulse(1'b1);
      repeat (4) @(negedge core_clk_in);
      `CHK("irq_cnt", 1, irq_n - n0)
      hc(4'h4, 1'b1, 1'b1, 1'b0, RP_NORMAL);
      for (int i = 1; i < 6; i++) hc(4'(i), 1'b0, 1'b1, 1'b0, e_wq[i]);
      hc(4'h7, 1'b0, 1'b1, 1'b0, RP_UNIMPL);
      rfc(1'b1, 1'b1, 1'b0, RA_SILENT);
      wait_extension_select_in = 1'b0;
      rfc(1'b1, 1'b1, 1'b0, RA_SILENT);
      rfc(1'b0, 1'b0, 1'b0, RA_SILENT);
      `CHK("state", ST_WQ, state_out)
      hc(4'h6, 1'b0, 1'b1, 1'b0, RP_ADVANCE);
      `CHK("state", ST_WA, state_out)
      // Commands spaced under the answer wait keep the tunnel alive
      for (int i = 1; i < 7; i++)
      begin
         hc(4'(i), 1'b0, 1'b1, 1'b0, e_wa[i]);
         repeat (10) @(negedge core_clk_in);
      end
      `CHK("state", ST_WA, state_out)
      hc(4'h7, 1'b0, 1'b1, 1'b0, RP_ADVANCE);
      wait_st(ST_RF);
      for (int k = 0; k < 60 && rf_final_req_out !== 1'b1; k++) @(negedge core_clk_in);
      `CHK("final_req", 1'b1, rf_final_req_out)
      if (rf_final_req_out !== 1'b1) stop_test();
      rdr.done();
      wait_st(ST_IDLE);
      // Carrier loss while waiting for the poll
      repeat (4) @(negedge rf_clk_in);
      rfc(1'b0, 1'b0, 1'b1, RA_NORMAL);
      wait_st(ST_RF);
      rdr.done();
      wait_st(ST_WQ);
      rdr.carrier(1'b0);
      wait_st(ST_IDLE);
      rdr.carrier(1'b1);
      repeat (20) @(negedge core_clk_in);
      stop_test();
   end
endmodule : rfhx_arbiter_test
